// file: common/itc_consts.svh
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH
// Register offsets on the plain register port
`define ITC_ADDR_ENABLE     4'h0
`define ITC_ADDR_CTRL       4'h1
`define ITC_ADDR_IRQ_STAT   4'h2
`define ITC_ADDR_IRQ_MASK   4'h3
`define ITC_ADDR_MODE_SHOW  4'h4
// Mode word field positions
`define ITC_MODE_MD_HI      7
`define ITC_MODE_MD_LO      6
`define ITC_MODE_SZ_HI      5
`define ITC_MODE_SZ_LO      4
`define ITC_MODE_SM_HI      3
`define ITC_MODE_SM_LO      2
// Control flags field positions
`define ITC_CTRL_SKIP       4
`define ITC_CTRL_CHAIN      3
`define ITC_CTRL_ERR        0
`define ITC_CTRL_WMASK      8'h18
// Interrupt status bits
`define ITC_IRQ_DONE        0
`define ITC_IRQ_ERR         1
`define ITC_IRQ_OVF         2
`define ITC_IRQ_W           3
// Reset values
`define ITC_ENABLE_RST      16'h0000
`define ITC_CTRL_RST        8'h00
// Source pointer steps
`define ITC_STEP_BYTE       32'h0000_0001
`define ITC_STEP_WORD       32'h0000_0002
`define ITC_STEP_LONG       32'h0000_0004
`endif

// file: common/itc_pkg.sv
package itc_pkg;
   typedef enum logic [1:0] {
      ITC_MD_NORMAL = 2'h0,
      ITC_MD_REPEAT = 2'h1,
      ITC_MD_BLOCK  = 2'h2,
      ITC_MD_BAD    = 2'h3
   } itc_mode_t;
   typedef enum logic [1:0] {
      ITC_SZ_BYTE = 2'h0,
      ITC_SZ_WORD = 2'h1,
      ITC_SZ_LONG = 2'h2,
      ITC_SZ_BAD  = 2'h3
   } itc_size_t;
   typedef enum {
      ITC_IDLE,
      ITC_XFER
   } itc_state_t;
endpackage

// file: testbench/itc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Transfer engine stand-in: finishes every started transfer late
module itc_far_model (
   input  wire logic       i_clk,
   input  wire logic       i_start,
   input  wire logic [2:0] i_lat,
   output logic            o_done
);
   int cnt = 0;
   // Done pulse i_lat+1 cycles after each start is sampled
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      if (i_start) begin
         cnt <= i_lat + 1;
      end else if (cnt == 1) begin
         o_done <= 1'b1;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// file: testbench/itc_transfer_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module itc_transfer_ctrl_test
   import itc_pkg::*;
;
   logic        i_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0;
   logic [3:0]  i_addr = 0;
   logic [31:0] i_wdata = 0, i_src_ptr = 0, o_rdata, o_src_ptr;
   logic [15:0] i_src_req = 0, o_cpu_irq, en_m = 0, arm_m = 0;
   logic [7:0]  i_mode_word = 0, ctl_m = 0, seed = 8'h34;
   logic [3:0]  o_xfer_src;
   logic [2:0]  lat = 1, st_m = 0, mask_m = 0;
   logic        i_each_sel = 0, i_last_xfer = 0, i_block_end = 0, i_area_ovf = 0;
   logic        o_xfer_start, o_src_wb, o_info_read_skip, o_chain_change_enable, o_irq, ovf_p = 0;
   wire         i_xfer_done;
   int          n_errors = 0, cmp_count = 0, cyc = 0;

   itc_transfer_ctrl u_itc_transfer_ctrl (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_src_req, .i_mode_word, .i_src_ptr, .i_each_sel, .i_last_xfer, .i_block_end, .i_area_ovf,
      .o_xfer_start, .o_xfer_src, .i_xfer_done, .o_src_ptr, .o_src_wb, .o_info_read_skip,
      .o_chain_change_enable, .o_cpu_irq, .o_irq);
   itc_far_model u_itc_far_model (.i_clk, .i_start(o_xfer_start), .i_lat(lat), .o_done(i_xfer_done));

   // 100 MHz clock
   always #5 i_clk = ~i_clk;

   function automatic logic [7:0] lfsr(logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   task automatic stop_test;
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Register write, model follows
   task automatic wr(logic [3:0] a, logic [31:0] d);
      logic [15:0] c;
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      c = ~d[15:0] & arm_m & en_m;
      if (a == 0) en_m = (en_m | d[15:0]) & ~c;
      if (a == 0) arm_m &= ~(d[15:0] | c);
      if (a == 1) ctl_m = (d[7:0] & 8'h18) | (ctl_m & d[7:0] & 8'h01);
      if (a == 2) st_m &= ~d[2:0];
      if (a == 3) mask_m = d[2:0];
   endtask

   // Register read, data checked in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", e, o_rdata);
      chk("irq", 32'(|(st_m & mask_m)), 32'(o_irq));
      if (a == 0) arm_m |= en_m;
   endtask

   // Request on src, plus source 15, with the given mode word and flags
   task automatic xfer(int src, logic [7:0] mw, logic ev, logic ls, logic be, logic ov);
      logic [31:0] p, s;
      logic        ok;
      int          n;
      ok = mw[7:6] != 2'h3 && mw[5:4] != 2'h3;
      p = {4{seed}};
      seed = lfsr(seed);
      @(posedge i_clk);
      i_mode_word <= mw;
      i_src_ptr <= p;
      i_each_sel <= ev;
      i_last_xfer <= ls;
      i_block_end <= be;
      i_src_req <= 16'h8000 | (16'h1 << src);
      lat <= ov ? 3'h4 : {1'b0, seed[1:0]} + 3'h1;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
         if (n == 1) chk("cpu_irq", 32'((16'h8000 | (16'h1 << src)) & ~en_m), 32'(o_cpu_irq));
      end while (!o_xfer_start && n < 8);
      chk("start", 32'(ok), 32'(o_xfer_start));
      @(posedge i_clk);
      i_src_req <= 16'h0;
      if (!ok) begin
         ctl_m |= 8'h01;
         st_m |= 3'h2;
         rd(1, 32'(ctl_m));
         return;
      end
      chk("src", src, 32'(o_xfer_src));
      i_area_ovf <= ov;
      @(posedge i_clk);
      i_area_ovf <= 1'b0;
      n = 0;
      while (!i_xfer_done && n < 12) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      @(posedge i_clk);
      #1;
      s = 32'h1 << mw[5:4];
      chk("wb", 32'(mw[3]), 32'(o_src_wb));
      if (mw[3]) chk("ptr", mw[2] ? p - s : p + s, o_src_ptr);
      if (ev | ls) en_m &= ~(16'h1 << src);
      if (ev | ls) arm_m &= ~(16'h1 << src);
      if (ev | ls) st_m |= 3'h1;
      if (mw[7:6] != 2'h2 && ov) st_m |= 3'h4;
      if (mw[7:6] == 2'h2 && ov) ovf_p = 1'b1;
      if (mw[7:6] == 2'h2 && be && ovf_p) st_m |= 3'h4;
      if (mw[7:6] == 2'h2 && be) ovf_p = 1'b0;
      rd(0, 32'(en_m));
      rd(2, 32'(st_m));
   endtask

   // Cut a hang short
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test;
      end
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd(0, 0);
      rd(1, 0);
      rd(4, 0);
      rd(5, 0);
      wr(1, 32'hff);
      rd(1, 32'h18);
      chk("skip", 1, 32'(o_info_read_skip));
      chk("chain", 1, 32'(o_chain_change_enable));
      wr(1, 0);
      wr(3, 7);
      for (int sz = 0; sz < 3; sz++) begin
         wr(0, 32'h1 << sz);
         for (int sm = 0; sm < 4; sm++) xfer(sz, {2'h0, 2'(sz), 2'(sm), 2'h0}, 0, 0, 0, 0);
      end
      wr(0, 32'h10);
      xfer(4, 8'h48, 1, 0, 0, 0);
      wr(0, 32'h8);
      xfer(3, 8'h08, 0, 1, 0, 1);
      wr(0, 32'h2);
      xfer(1, 8'h98, 0, 0, 0, 1);
      xfer(1, 8'h98, 0, 0, 1, 0);
      xfer(1, 8'hc0, 0, 0, 0, 0);
      xfer(1, 8'h30, 0, 0, 0, 0);
      wr(1, 32'h1);
      rd(1, 32'(ctl_m));
      wr(1, 0);
      rd(1, 0);
      wr(3, 0);
      rd(2, 32'(st_m));
      wr(3, 7);
      wr(2, 7);
      rd(2, 0);
      wr(0, 0);
      wr(0, 32'h2);
      wr(0, 0);
      rd(0, 32'h2);
      wr(0, 0);
      rd(0, 0);
      stop_test;
   end
endmodule
`default_nettype wire

// file: verilog/itc_transfer_ctrl.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.svh"
// What this block does
// RL1: mode field 00 normal, 01 repeat, 10 block; 11 prohibited.
// RL2: size field 00 byte, 01 word, 10 longword; 11 prohibited.
// RL3: source step 0x keeps pointer fixed and skips its write-back.
// RL4: source step 10 adds 1, 2 or 4 by size after each transfer.
// RL5: source step 11 subtracts 1, 2 or 4 by size after each transfer.
// RL6: mode word is transfer information, not CPU reachable, undefined at reset.
// RL7: each of sixteen enable bits turns its interrupt source into a transfer start.
// RL8: enable bit clears when software writes 0 after reading it as 1.
// RL9: enable bit auto-clears after transfer when interrupt-after-each select is 1.
// RL10: enable bit auto-clears once programmed transfer count completes.
// RL11: enable bit stays set when select is 0 and count not reached.
// RL12: block-mode repeat-area overflow holds interrupt off until block ends.
// RL13: software makes block size power of two or boundary-aligned.
// RL14: error flag clears on written 0; written 1 has no effect.
// RL15: control bits 7 to 5 read as 0.
// RL16: control register holds info-read-skip and chain-change enable.
// RL17: prohibited mode or size encodings flag an error, start nothing.
module itc_transfer_ctrl
   import itc_pkg::*;
#(
   parameter int N_SRC = 16
) (
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic [3:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   input  wire logic [N_SRC-1:0]  i_src_req,
   input  wire logic [7:0]        i_mode_word,
   input  wire logic [31:0]       i_src_ptr,
   input  wire logic              i_each_sel,
   input  wire logic              i_last_xfer,
   input  wire logic              i_block_end,
   input  wire logic              i_area_ovf,
   output logic                   o_xfer_start,
   output logic      [3:0]        o_xfer_src,
   input  wire logic              i_xfer_done,
   output logic      [31:0]       o_src_ptr,
   output logic                   o_src_wb,
   output logic                   o_info_read_skip,
   output logic                   o_chain_change_enable,
   output logic      [N_SRC-1:0]  o_cpu_irq,
   output logic                   o_irq
);

   logic             rst_s1_q, rst_n_q;
   logic [N_SRC-1:0] en_q;
   logic [N_SRC-1:0] en_seen_q;
   logic [7:0]       ctrl_q;
   logic [`ITC_IRQ_W-1:0] stat_q, mask_q;
   logic [7:0]       mode_q;
   logic [3:0]       src_q;
   logic             ovf_pend_q;
   itc_state_t       state_q;
   logic             start_ok;
   logic             bad_cfg;
   logic [3:0]       pick;
   logic             any_req;
   logic [31:0]      step;
   logic             clr_done;
   logic             ovf_evt;

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // Lowest pending enabled source wins
   // RL7: enabled sources start transfers
   always_comb begin
      pick    = 4'h0;
      any_req = 1'b0;
      for (int i = N_SRC-1; i >= 0; i--) begin
         if (i_src_req[i] && en_q[i]) begin
            pick    = 4'(i);
            any_req = 1'b1;
         end
      end
   end

   // Disabled sources go to the CPU
   assign o_cpu_irq = i_src_req & ~en_q;

   // RL1: RL2: RL17: prohibited encodings
   assign bad_cfg  = (itc_mode_t'(i_mode_word[`ITC_MODE_MD_HI:`ITC_MODE_MD_LO]) == ITC_MD_BAD) ||
                     (itc_size_t'(i_mode_word[`ITC_MODE_SZ_HI:`ITC_MODE_SZ_LO]) == ITC_SZ_BAD);
   assign start_ok = (state_q == ITC_IDLE) && any_req && !bad_cfg;

   // Transfer sequencer; mode word latched as private info
   // RL6: mode word only from transfer information
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q      <= ITC_IDLE;
         src_q        <= 4'h0;
         mode_q       <= 8'h00;
         o_xfer_start <= 1'b0;
      end else begin
         o_xfer_start <= 1'b0;
         unique case (state_q)
            ITC_IDLE: begin
               if (start_ok) begin
                  state_q      <= ITC_XFER;
                  src_q        <= pick;
                  mode_q       <= i_mode_word;
                  o_xfer_start <= 1'b1;
               end
            end
            ITC_XFER: begin
               if (i_xfer_done) begin
                  state_q <= ITC_IDLE;
               end
            end
         endcase
      end
   end
   assign o_xfer_src = src_q;

   // Step by size
   // RL4: RL5: step 1, 2 or 4
   always_comb begin
      unique case (itc_size_t'(mode_q[`ITC_MODE_SZ_HI:`ITC_MODE_SZ_LO]))
         ITC_SZ_BYTE: step = `ITC_STEP_BYTE;
         ITC_SZ_WORD: step = `ITC_STEP_WORD;
         ITC_SZ_LONG: step = `ITC_STEP_LONG;
         ITC_SZ_BAD:  step = 32'h0000_0000;
      endcase
   end

   // Source pointer update at transfer end
   // RL3: fixed pointer, no write-back
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_src_ptr <= 32'h0000_0000;
         o_src_wb  <= 1'b0;
      end else begin
         o_src_wb <= 1'b0;
         if (state_q == ITC_XFER && i_xfer_done && mode_q[`ITC_MODE_SM_HI]) begin
            o_src_wb <= 1'b1;
            // RL4: RL5: increment or decrement
            if (mode_q[`ITC_MODE_SM_LO]) begin
               o_src_ptr <= i_src_ptr - step;
            end else begin
               o_src_ptr <= i_src_ptr + step;
            end
         end
      end
   end

   assign clr_done = (state_q == ITC_XFER) && i_xfer_done && (i_each_sel || i_last_xfer);

   // Enable reset pattern, one bit per source
   localparam logic [N_SRC-1:0] EN_RST = N_SRC'(`ITC_ENABLE_RST);

   // Enable bits: write, read-then-zero clear, auto clear
   generate
      for (genvar g = 0; g < N_SRC; g++) begin : g_en
         always_ff @(posedge i_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               en_q[g]      <= EN_RST[g];
               en_seen_q[g] <= 1'b0;
            end else begin
               if (i_rd && i_addr == `ITC_ADDR_ENABLE && en_q[g]) begin
                  en_seen_q[g] <= 1'b1;
               end
               if (i_wr && i_addr == `ITC_ADDR_ENABLE) begin
                  if (i_wdata[g]) begin
                     en_q[g] <= 1'b1;
                  // RL8: zero after read-as-one
                  end else if (en_seen_q[g]) begin
                     en_q[g]      <= 1'b0;
                     en_seen_q[g] <= 1'b0;
                  end
               end
               // RL9: RL10: RL11: auto clear, else kept
               if (clr_done && src_q == 4'(g)) begin
                  en_q[g]      <= 1'b0;
                  en_seen_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Control flags
   // RL14: RL15: RL16: control writes
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= `ITC_CTRL_RST;
      end else begin
         if (i_wr && i_addr == `ITC_ADDR_CTRL) begin
            ctrl_q[`ITC_CTRL_SKIP]  <= i_wdata[`ITC_CTRL_SKIP];
            ctrl_q[`ITC_CTRL_CHAIN] <= i_wdata[`ITC_CTRL_CHAIN];
            if (!i_wdata[`ITC_CTRL_ERR]) begin
               ctrl_q[`ITC_CTRL_ERR] <= 1'b0;
            end
         end
         // RL17: set wins over clear
         if (state_q == ITC_IDLE && any_req && bad_cfg) begin
            ctrl_q[`ITC_CTRL_ERR] <= 1'b1;
         end
      end
   end
   assign o_info_read_skip      = ctrl_q[`ITC_CTRL_SKIP];
   assign o_chain_change_enable = ctrl_q[`ITC_CTRL_CHAIN];

   // Overflow held until block end in block mode
   // RL12: overflow deferred in block
   assign ovf_evt = (itc_mode_t'(mode_q[`ITC_MODE_MD_HI:`ITC_MODE_MD_LO]) == ITC_MD_BLOCK) ?
                    ((ovf_pend_q || i_area_ovf) && i_block_end && i_xfer_done) : i_area_ovf;
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ovf_pend_q <= 1'b0;
      end else if (ovf_evt) begin
         ovf_pend_q <= 1'b0;
      end else if (i_area_ovf) begin
         ovf_pend_q <= 1'b1;
      end
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_q <= '0;
         mask_q <= '0;
      end else begin
         if (i_wr && i_addr == `ITC_ADDR_IRQ_MASK) begin
            mask_q <= i_wdata[`ITC_IRQ_W-1:0];
         end
         stat_q <= (stat_q & ~((i_wr && i_addr == `ITC_ADDR_IRQ_STAT) ? i_wdata[`ITC_IRQ_W-1:0] : '0))
                 | {ovf_evt, (state_q == ITC_IDLE && any_req && bad_cfg), clr_done};
      end
   end
   assign o_irq = |(stat_q & mask_q);

   // Read data, one cycle after the strobe
   // RL15: top control bits zero
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            `ITC_ADDR_ENABLE:    o_rdata <= 32'(en_q);
            `ITC_ADDR_CTRL:      o_rdata <= {24'h00_0000, 3'h0, ctrl_q[4:0]};
            `ITC_ADDR_IRQ_STAT:  o_rdata <= 32'(stat_q);
            `ITC_ADDR_IRQ_MASK:  o_rdata <= 32'(mask_q);
            `ITC_ADDR_MODE_SHOW: o_rdata <= {31'h0, state_q == ITC_XFER};
            default:             o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // Checks
   sequence s_done_each;
      state_q == ITC_XFER && i_xfer_done && (i_each_sel || i_last_xfer);
   endsequence
   sequence s_bad_request;
      state_q == ITC_IDLE && any_req && bad_cfg;
   endsequence
   sequence s_enable_write;
      i_wr && i_addr == `ITC_ADDR_ENABLE && !clr_done;
   endsequence
   sequence s_block_close;
      itc_mode_t'(mode_q[`ITC_MODE_MD_HI:`ITC_MODE_MD_LO]) == ITC_MD_BLOCK &&
      (ovf_pend_q || i_area_ovf) && i_block_end && i_xfer_done;
   endsequence
   // Request taken, then start pulse one cycle later
   sequence s_start_busy;
      start_ok ##1 o_xfer_start;
   endsequence
   chk_bad_no_start: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL17
      (any_req && bad_cfg && state_q == ITC_IDLE) |=> !o_xfer_start)
      else $error("prohibited setting started a transfer");
   chk_err_flag_set: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL17
      (any_req && bad_cfg && state_q == ITC_IDLE) |=> ctrl_q[`ITC_CTRL_ERR])
      else $error("error flag not set");
   chk_auto_clear: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL9
      s_done_each |=> !en_q[src_q])
      else $error("enable not auto cleared");
   chk_keep_enable: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL11
      (state_q == ITC_XFER && i_xfer_done && !i_each_sel && !i_last_xfer && en_q[src_q] && !i_wr)
      |=> en_q[$past(src_q)])
      else $error("enable dropped early");
   chk_fixed_no_wb: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL3
      (state_q == ITC_XFER && i_xfer_done && !mode_q[`ITC_MODE_SM_HI]) |=> !o_src_wb)
      else $error("fixed pointer written back");
   chk_ptr_inc: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL4
      (state_q == ITC_XFER && i_xfer_done && mode_q[`ITC_MODE_SM_HI:`ITC_MODE_SM_LO] == 2'h2)
      |=> o_src_ptr == $past(i_src_ptr) + $past(step))
      else $error("pointer increment wrong");
   chk_ptr_dec: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL5
      (state_q == ITC_XFER && i_xfer_done && mode_q[`ITC_MODE_SM_HI:`ITC_MODE_SM_LO] == 2'h3)
      |=> o_src_ptr == $past(i_src_ptr) - $past(step))
      else $error("pointer decrement wrong");
   chk_ctrl_top_zero: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL15
      (i_rd && i_addr == `ITC_ADDR_CTRL) |=> o_rdata[7:5] == 3'h0)
      else $error("reserved control bits nonzero");
   chk_block_ovf_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL12
      (itc_mode_t'(mode_q[`ITC_MODE_MD_HI:`ITC_MODE_MD_LO]) == ITC_MD_BLOCK && i_area_ovf && !i_block_end)
      |=> !stat_q[`ITC_IRQ_OVF] || $past(stat_q[`ITC_IRQ_OVF]))
      else $error("overflow not held in block");
   chk_start_source: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      o_xfer_start |-> en_q[src_q] || $past(en_q[src_q]))
      else $error("start from disabled source");

   // Start pulse and held transfer context
   chk_start_taken: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      start_ok |=> o_xfer_start && o_xfer_src == $past(pick))
      else $error("accepted request did not start");
   chk_busy_flag: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      s_start_busy |-> state_q == ITC_XFER)
      else $error("busy not entered after start");
   chk_start_pulse: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      o_xfer_start |=> !o_xfer_start)
      else $error("start pulse longer than one cycle");
   chk_busy_no_start: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      (state_q == ITC_XFER && !i_xfer_done) |=> !o_xfer_start)
      else $error("start while busy");
   chk_src_held: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      (state_q == ITC_XFER) |=> $stable(o_xfer_src))
      else $error("source changed during transfer");
   chk_mode_held: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL6
      (state_q == ITC_XFER) |=> $stable(mode_q))
      else $error("mode word changed during transfer");

   // Enable bit write and clear paths
   chk_en_write_one: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL7
      s_enable_write |=> (en_q & $past(i_wdata[N_SRC-1:0])) == $past(i_wdata[N_SRC-1:0]))
      else $error("enable not set by written one");
   chk_en_zero_unread: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL8
      s_enable_write |=> ($past(en_q) & ~$past(en_seen_q) & ~$past(i_wdata[N_SRC-1:0]) & ~en_q) == '0)
      else $error("unread enable cleared by zero");
   chk_en_zero_seen: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL8
      s_enable_write |=> ($past(en_seen_q) & ~$past(i_wdata[N_SRC-1:0]) & en_q) == '0)
      else $error("read enable not cleared by zero");
   chk_last_clear: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL10
      (state_q == ITC_XFER && i_xfer_done && i_last_xfer) |=> !en_q[src_q])
      else $error("enable kept after last transfer");

   // Status and control flags
   chk_done_status: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL9
      s_done_each |=> stat_q[`ITC_IRQ_DONE])
      else $error("done status not set");
   chk_err_status: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL17
      s_bad_request |=> stat_q[`ITC_IRQ_ERR])
      else $error("error status not set");
   chk_err_write_clr: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL14
      (i_wr && i_addr == `ITC_ADDR_CTRL && !i_wdata[`ITC_CTRL_ERR] && !(any_req && bad_cfg))
      |=> !ctrl_q[`ITC_CTRL_ERR])
      else $error("error flag not cleared by zero");
   chk_err_write_one: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL14
      (i_wr && i_addr == `ITC_ADDR_CTRL && i_wdata[`ITC_CTRL_ERR] && !ctrl_q[`ITC_CTRL_ERR] &&
       !(any_req && bad_cfg)) |=> !ctrl_q[`ITC_CTRL_ERR])
      else $error("error flag set by written one");
   chk_skip_follows: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL16
      (i_wr && i_addr == `ITC_ADDR_CTRL) |=> o_info_read_skip == $past(i_wdata[`ITC_CTRL_SKIP]))
      else $error("read skip not written");
   chk_chain_follows: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL16
      (i_wr && i_addr == `ITC_ADDR_CTRL) |=> o_chain_change_enable == $past(i_wdata[`ITC_CTRL_CHAIN]))
      else $error("chain enable not written");

   // Overflow outside and at end of a block
   chk_ovf_at_once: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL12
      (itc_mode_t'(mode_q[`ITC_MODE_MD_HI:`ITC_MODE_MD_LO]) != ITC_MD_BLOCK && i_area_ovf)
      |=> stat_q[`ITC_IRQ_OVF])
      else $error("overflow status late outside block");
   chk_ovf_block_end: assert property (@(posedge i_clk) disable iff (!rst_n_q) // RL12
      s_block_close |=> stat_q[`ITC_IRQ_OVF])
      else $error("held overflow lost at block end");

endmodule
`default_nettype wire
